// ---- inc/mit_pkg.sv ----
// Purpose: Shared constants and types for the instruction timing core
// Assumes: 16-bit instruction words, 8-bit data path, 11-bit program counter
// Notes:   Opcode map lives here so the bench can assemble programs
package mit_pkg;

    // ==========================================================
    // Widths and sizes
    localparam int PC_W        = 11;
    localparam int STACK_DEPTH = 8;
    localparam int DMEM_WORDS  = 256;

    // ==========================================================
    // Timing
    localparam int           CLKS_PER_CYCLE = 4;
    localparam logic [1:0]   PHASE_EXEC     = 2'h3;

    // ==========================================================
    // Instruction word fields: op [15:11], bit [10:8], operand [7:0]
    localparam int OP_MSB   = 15;
    localparam int OP_LSB   = 11;
    localparam int BIT_MSB  = 10;
    localparam int BIT_LSB  = 8;
    localparam int DEST_BIT = 8;

    // ==========================================================
    // Data memory map of core-held registers
    localparam logic [7:0] ADDR_PC_LOW    = 8'h00;
    localparam logic [7:0] ADDR_TBL_LOW   = 8'h01;
    localparam logic [7:0] ADDR_TBL_HIGH  = 8'h02;
    localparam logic [7:0] ADDR_TBL_DATAH = 8'h03;

    // ==========================================================
    // Reset values
    localparam logic [PC_W-1:0] PC_RESET  = 11'h000;
    localparam logic [7:0]      BYTE_ZERO = 8'h00;

    // ==========================================================
    // Opcodes
    typedef enum logic [4:0] {
        OP_NOP      = 5'h00,
        OP_MOV_AM   = 5'h01,
        OP_MOV_MA   = 5'h02,
        OP_MOV_AX   = 5'h03,
        OP_ADD_AM   = 5'h04,
        OP_ADD_AX   = 5'h05,
        OP_ADC_AM   = 5'h06,
        OP_SUB_AM   = 5'h07,
        OP_SUB_AX   = 5'h08,
        OP_SBC_AM   = 5'h09,
        OP_AND_AM   = 5'h0A,
        OP_OR_AM    = 5'h0B,
        OP_XOR_AM   = 5'h0C,
        OP_AND_AX   = 5'h0D,
        OP_INV_M    = 5'h0E,
        OP_INV_A    = 5'h0F,
        OP_INC_M    = 5'h10,
        OP_INC_A    = 5'h11,
        OP_DEC_M    = 5'h12,
        OP_DEC_A    = 5'h13,
        OP_ROT_R    = 5'h14,
        OP_ROT_L    = 5'h15,
        OP_ROT_RC   = 5'h16,
        OP_ROT_LC   = 5'h17,
        OP_BIT_HIGH = 5'h18,
        OP_BIT_LOW  = 5'h19,
        OP_SKIP_Z   = 5'h1A,
        OP_SKIP_BZ  = 5'h1B,
        OP_SKIP_BNZ = 5'h1C,
        OP_JUMP     = 5'h1D,
        OP_CALL     = 5'h1E,
        OP_MISC     = 5'h1F
    } mit_op_t;

    // Sub-operations of OP_MISC, in the bit field
    localparam logic [2:0] MISC_RET   = 3'h0;
    localparam logic [2:0] MISC_INTERRUPT_EXIT  = 3'h1;
    localparam logic [2:0] MISC_TABLE = 3'h2;
    localparam logic [2:0] MISC_HALT  = 3'h3;
    localparam logic [2:0] MISC_WDT   = 3'h4;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_FLUSH,
        ST_TABLE,
        ST_SLEEP
    } mit_state_t;

endpackage

// ---- design/mit_core.sv ----
// Purpose: 8-bit core with a four-clock instruction cycle and two-cycle flow changes
// Assumes: prog_data_i answers prog_addr_o within the same instruction cycle
// Notes:   Data memory is held inside; writes are echoed on the store port
//
// Operation
// - Most instructions take one instruction cycle; branch, call and table read take two.
// - One instruction cycle lasts exactly four system clocks.
// - Jump, call, subroutine exit, interrupt exit and table read each add one instruction cycle.
// - Writing the program counter low byte jumps to the new address and costs one more cycle.
// - A skip test takes one cycle when not taken and two when it skips.
// - Add reports carry above 255 and subtract reports borrow below 0, for chaining.
// - Plus-one and minus-one change the operand by one, to memory or to the accumulator.
// - AND, OR, XOR and bit inversion set zero on a zero result and clear it otherwise.
// - Rotates move one bit left or right, via-carry forms shift carry in and out.
// - A call saves the next address and the subroutine exit resumes there.
// - An unconditional jump loads the target without saving a return address.
// - Conditional branches test a byte or a bit and skip the next instruction when true.
// - Bit force-high and force-low rewrite the byte changing only the selected bit.
// - Table read fetches constant data from program memory into the data path.
// - Transfers go memory to accumulator, accumulator to memory, immediate to accumulator.
// - Power-down enters the sleep state; a separate instruction clears the watchdog.
`timescale 1ns/1ns

module mit_core
    import mit_pkg::*;
(
    input  wire logic             clk_sys_i,    // System clock, 10 MHz
    input  wire logic             resetn_i,     // Synchronous reset, active low
    input  wire logic [15:0]      prog_data_i,  // Program memory word
    input  wire logic             wake_i,       // Leaves power-down
    output logic      [PC_W-1:0]  prog_addr_o,  // Program memory address
    output logic      [PC_W-1:0]  pc_o,         // Program counter
    output logic      [7:0]       acc_o,        // Accumulator
    output logic                  zero_o,       // Zero flag
    output logic                  carry_o,      // Carry or borrow flag
    output logic                  int_en_o,     // Interrupt enable, set by interrupt exit
    output logic                  sleep_o,      // Power-down state
    output logic                  wdt_clear_o,  // Watchdog clear pulse
    output logic                  cycle_end_o,  // Pulse at end of each instruction cycle
    output logic                  store_stb_o,  // Data memory write pulse
    output logic      [7:0]       store_addr_o, // Data memory write address
    output logic      [7:0]       store_data_o  // Data memory write data
);

    // ==========================================================
    // State
    mit_state_t            state_q;
    logic [1:0]            phase_q;
    logic [PC_W-1:0]       pc_q;
    logic [7:0]            acc_q;
    logic                  zero_q;
    logic                  carry_q;
    logic [7:0]            tbl_low_q;
    logic [7:0]            tbl_high_q;
    logic [7:0]            tbl_datah_q;
    logic [2:0]            sp_q;
    logic [PC_W-1:0]       stack_q [STACK_DEPTH];
    logic [7:0]            dmem_q  [DMEM_WORDS];

    logic                  exec;
    logic [15:0]           ir;
    mit_op_t               op;
    logic [2:0]            bsel;
    logic [7:0]            opnd;
    logic [7:0]            mval;
    logic [PC_W-1:0]       pc_inc;
    logic [PC_W-1:0]       tbl_addr;

    logic [8:0]            res;
    logic                  wr_acc;
    logic                  wr_mem;
    logic                  upd_z;
    logic                  upd_c;
    logic                  c_new;
    logic                  skip;
    logic                  jump;
    logic [PC_W-1:0]       target;
    logic                  push;
    logic                  pop;
    logic                  set_ie;
    logic                  tbl_rd;
    logic                  halt;
    logic                  wdt;
    logic                  pcl_wr;

    // Only the run state executes; flush and table cycles never decode
    assign exec     = (state_q == ST_RUN) && (phase_q == PHASE_EXEC);
    assign ir       = prog_data_i;
    assign op       = mit_op_t'(ir[OP_MSB:OP_LSB]);
    assign bsel     = ir[BIT_MSB:BIT_LSB];
    assign opnd     = ir[7:0];
    assign pc_inc   = pc_q + 11'h001;
    assign tbl_addr = {tbl_high_q[2:0], tbl_low_q};
    assign pcl_wr   = wr_mem && (opnd == ADDR_PC_LOW);

    // ==========================================================
    // Operand read
    always_comb
    begin
        unique case (opnd)
            ADDR_PC_LOW:    mval = pc_q[7:0];
            ADDR_TBL_LOW:   mval = tbl_low_q;
            ADDR_TBL_HIGH:  mval = tbl_high_q;
            ADDR_TBL_DATAH: mval = tbl_datah_q;
            default:        mval = dmem_q[opnd];
        endcase
    end

    // ==========================================================
    // Decode and data path
    always_comb
    begin
        res    = {1'b0, mval};
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        upd_z  = 1'b0;
        upd_c  = 1'b0;
        c_new  = carry_q;
        skip   = 1'b0;
        jump   = 1'b0;
        target = ir[PC_W-1:0];
        push   = 1'b0;
        pop    = 1'b0;
        set_ie = 1'b0;
        tbl_rd = 1'b0;
        halt   = 1'b0;
        wdt    = 1'b0;
        unique case (op)
            OP_NOP:      res = {1'b0, acc_q};
            OP_MOV_AM:   wr_acc = 1'b1;
            OP_MOV_MA:
            begin
                res    = {1'b0, acc_q};
                wr_mem = 1'b1;
            end
            OP_MOV_AX:   wr_acc = 1'b1;
            OP_ADD_AM, OP_ADD_AX, OP_ADC_AM:
            begin
                res    = {1'b0, acc_q} + {1'b0, mval} + {8'h00, op == OP_ADC_AM && carry_q};
                wr_acc = 1'b1;
                upd_z  = 1'b1;
                upd_c  = 1'b1;
                c_new  = res[8];
            end
            OP_SUB_AM, OP_SUB_AX, OP_SBC_AM:
            begin
                res    = {1'b0, acc_q} - {1'b0, mval} - {8'h00, op == OP_SBC_AM && carry_q};
                wr_acc = 1'b1;
                upd_z  = 1'b1;
                upd_c  = 1'b1;
                c_new  = res[8];
            end
            OP_AND_AM, OP_AND_AX:
            begin
                res    = {1'b0, acc_q & mval};
                wr_acc = 1'b1;
                upd_z  = 1'b1;
            end
            OP_OR_AM:
            begin
                res    = {1'b0, acc_q | mval};
                wr_acc = 1'b1;
                upd_z  = 1'b1;
            end
            OP_XOR_AM:
            begin
                res    = {1'b0, acc_q ^ mval};
                wr_acc = 1'b1;
                upd_z  = 1'b1;
            end
            OP_INV_M, OP_INV_A:
            begin
                res    = {1'b0, ~mval};
                wr_acc = (op == OP_INV_A);
                wr_mem = (op == OP_INV_M);
                upd_z  = 1'b1;
            end
            OP_INC_M, OP_INC_A:
            begin
                res    = {1'b0, mval + 8'h01};
                wr_acc = (op == OP_INC_A);
                wr_mem = (op == OP_INC_M);
                upd_z  = 1'b1;
            end
            OP_DEC_M, OP_DEC_A:
            begin
                res    = {1'b0, mval - 8'h01};
                wr_acc = (op == OP_DEC_A);
                wr_mem = (op == OP_DEC_M);
                upd_z  = 1'b1;
            end
            OP_ROT_R, OP_ROT_L, OP_ROT_RC, OP_ROT_LC:
            begin
                unique case (op)
                    OP_ROT_R:  res = {1'b0, mval[0], mval[7:1]};
                    OP_ROT_L:  res = {1'b0, mval[6:0], mval[7]};
                    OP_ROT_RC: res = {mval[0], carry_q, mval[7:1]};
                    default:   res = {mval[7], mval[6:0], carry_q};
                endcase
                upd_c  = (op == OP_ROT_RC) || (op == OP_ROT_LC);
                c_new  = res[8];
                wr_acc = ir[DEST_BIT];
                wr_mem = !ir[DEST_BIT];
            end
            OP_BIT_HIGH:
            begin
                res    = {1'b0, mval | (8'h01 << bsel)};
                wr_mem = 1'b1;
            end
            OP_BIT_LOW:
            begin
                res    = {1'b0, mval & ~(8'h01 << bsel)};
                wr_mem = 1'b1;
            end
            OP_SKIP_Z:   skip = (mval == BYTE_ZERO);
            OP_SKIP_BZ:  skip = !mval[bsel];
            OP_SKIP_BNZ: skip = mval[bsel];
            OP_JUMP:     jump = 1'b1;
            OP_CALL:
            begin
                jump = 1'b1;
                push = 1'b1;
            end
            OP_MISC:
            begin
                unique case (bsel)
                    MISC_RET, MISC_INTERRUPT_EXIT:
                    begin
                        jump   = 1'b1;
                        pop    = 1'b1;
                        target = stack_q[sp_q - 3'h1];
                        set_ie = (bsel == MISC_INTERRUPT_EXIT);
                    end
                    MISC_TABLE: tbl_rd = 1'b1;
                    MISC_HALT:  halt = 1'b1;
                    MISC_WDT:   wdt = 1'b1;
                    default:    res = {1'b0, acc_q};
                endcase
            end
        endcase
        // Immediate forms take the operand field itself
        if (op == OP_MOV_AX || op == OP_ADD_AX || op == OP_SUB_AX || op == OP_AND_AX)
        begin
            unique case (op)
                OP_MOV_AX: res = {1'b0, opnd};
                OP_ADD_AX: res = {1'b0, acc_q} + {1'b0, opnd};
                OP_SUB_AX: res = {1'b0, acc_q} - {1'b0, opnd};
                default:   res = {1'b0, acc_q & opnd};
            endcase
            c_new = (op == OP_AND_AX || op == OP_MOV_AX) ? carry_q : res[8];
        end
    end

    // ==========================================================
    // Four-clock instruction cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            phase_q     <= 2'h0;
            cycle_end_o <= 1'b0;
        end
        else
        begin
            phase_q     <= phase_q + 2'h1;
            cycle_end_o <= (phase_q == PHASE_EXEC) && (state_q != ST_SLEEP);
        end
    end

    // ==========================================================
    // Sequencing: every flow change buys one dropped cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            state_q <= ST_RUN;
            pc_q    <= PC_RESET;
        end
        else if (phase_q == PHASE_EXEC)
        begin
            unique case (state_q)
                ST_RUN:
                begin
                    if (jump)
                    begin
                        pc_q    <= target;
                        state_q <= ST_FLUSH;
                    end
                    else if (pcl_wr)
                    begin
                        pc_q    <= {pc_q[PC_W-1:8], res[7:0]};
                        state_q <= ST_FLUSH;
                    end
                    else if (skip)
                    begin
                        pc_q    <= pc_q + 11'h002;
                        state_q <= ST_FLUSH;
                    end
                    else if (tbl_rd)
                    begin
                        pc_q    <= pc_inc;
                        state_q <= ST_TABLE;
                    end
                    else if (halt)
                    begin
                        pc_q    <= pc_inc;
                        state_q <= ST_SLEEP;
                    end
                    else
                    begin
                        pc_q    <= pc_inc;
                    end
                end
                ST_FLUSH, ST_TABLE: state_q <= ST_RUN;
                ST_SLEEP:           state_q <= wake_i ? ST_RUN : ST_SLEEP;
            endcase
        end
    end

    // ==========================================================
    // Accumulator, flags and table latch
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            acc_q       <= BYTE_ZERO;
            zero_q      <= 1'b0;
            carry_q     <= 1'b0;
            tbl_datah_q <= BYTE_ZERO;
            int_en_o    <= 1'b0;
        end
        else if (exec)
        begin
            if (wr_acc)
                acc_q <= res[7:0];
            if (upd_z)
                zero_q <= (res[7:0] == BYTE_ZERO);
            if (upd_c)
                carry_q <= c_new;
            if (set_ie)
                int_en_o <= 1'b1;
        end
        else if (state_q == ST_TABLE && phase_q == PHASE_EXEC)
        begin
            acc_q       <= prog_data_i[7:0];
            tbl_datah_q <= prog_data_i[15:8];
        end
    end

    // ==========================================================
    // Return stack; wraps silently when overfilled
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            sp_q <= 3'h0;
        else if (exec && push)
        begin
            stack_q[sp_q] <= pc_inc;
            sp_q          <= sp_q + 3'h1;
        end
        else if (exec && pop)
            sp_q <= sp_q - 3'h1;
    end

    // ==========================================================
    // Data memory and pointer registers
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            tbl_low_q    <= BYTE_ZERO;
            tbl_high_q   <= BYTE_ZERO;
            store_stb_o  <= 1'b0;
            store_addr_o <= BYTE_ZERO;
            store_data_o <= BYTE_ZERO;
        end
        else
        begin
            store_stb_o <= exec && wr_mem;
            if (exec && wr_mem)
            begin
                store_addr_o <= opnd;
                store_data_o <= res[7:0];
                unique case (opnd)
                    ADDR_PC_LOW, ADDR_TBL_DATAH: ;
                    ADDR_TBL_LOW:  tbl_low_q  <= res[7:0];
                    ADDR_TBL_HIGH: tbl_high_q <= res[7:0];
                    default:       dmem_q[opnd] <= res[7:0];
                endcase
            end
        end
    end

    // ==========================================================
    // Registered outputs
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            prog_addr_o <= PC_RESET;
            pc_o        <= PC_RESET;
            acc_o       <= BYTE_ZERO;
            zero_o      <= 1'b0;
            carry_o     <= 1'b0;
            sleep_o     <= 1'b0;
            wdt_clear_o <= 1'b0;
        end
        else
        begin
            prog_addr_o <= (state_q == ST_TABLE) ? tbl_addr : pc_q;
            pc_o        <= pc_q;
            acc_o       <= acc_q;
            zero_o      <= zero_q;
            carry_o     <= carry_q;
            sleep_o     <= (state_q == ST_SLEEP);
            wdt_clear_o <= exec && wdt;
        end
    end

endmodule

// ---- tb/mit_core_properties.sv ----
// Purpose: Port-level assertions for the instruction timing core
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to every mit_core instance
`timescale 1ns/1ns

module mit_core_properties
    import mit_pkg::*;
(
    input wire logic            clk_sys_i,    // System clock
    input wire logic            resetn_i,     // Reset, active low
    input wire logic [15:0]     prog_data_i,  // Program word
    input wire logic            wake_i,       // Wake request
    input wire logic [PC_W-1:0] prog_addr_o,  // Program address
    input wire logic [PC_W-1:0] pc_o,         // Program counter
    input wire logic [7:0]      acc_o,        // Accumulator
    input wire logic            zero_o,       // Zero flag
    input wire logic            carry_o,      // Carry flag
    input wire logic            int_en_o,     // Interrupt enable
    input wire logic            sleep_o,      // Power-down
    input wire logic            wdt_clear_o,  // Watchdog clear
    input wire logic            cycle_end_o,  // Cycle end pulse
    input wire logic            store_stb_o,  // Write pulse
    input wire logic [7:0]      store_addr_o, // Write address
    input wire logic [7:0]      store_data_o  // Write data
);
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    a_cycle_four_clocks: assert property (cycle_end_o |=> (!cycle_end_o) [*3])
        else $error("cycle end pulses closer than four clocks");
    a_cycle_rhythm: assert property (cycle_end_o ##1 (!cycle_end_o) [*3] ##1 !sleep_o |-> cycle_end_o)
        else $error("cycle end missing after four clocks");
    a_store_in_cycle: assert property (store_stb_o |-> cycle_end_o)
        else $error("store pulse outside cycle end");
    a_wdt_in_cycle: assert property (wdt_clear_o |-> cycle_end_o)
        else $error("watchdog clear outside cycle end");
    // Registered copies move one clock after the cycle-end pulse
    a_pc_moves_at_end: assert property ($changed(pc_o) |-> $past(cycle_end_o))
        else $error("program counter moved inside a cycle");
    a_acc_moves_at_end: assert property ($changed(acc_o) |-> $past(cycle_end_o))
        else $error("accumulator moved inside a cycle");
    a_flags_at_end: assert property ($changed({zero_o, carry_o}) |-> $past(cycle_end_o))
        else $error("flags moved inside a cycle");
    a_sleep_no_cycles: assert property (sleep_o && $past(sleep_o) |-> !cycle_end_o)
        else $error("cycle ran during power-down");
    a_int_en_sticky: assert property ($past(int_en_o) |-> int_en_o)
        else $error("interrupt enable dropped without reset");

    c_store: cover property (store_stb_o);
    c_wdt: cover property (wdt_clear_o);
    c_sleep: cover property ($rose(sleep_o));
endmodule

bind mit_core mit_core_properties mit_core_properties_inst (.clk_sys_i, .resetn_i, .prog_data_i, .wake_i,
    .prog_addr_o, .pc_o, .acc_o, .zero_o, .carry_o, .int_en_o, .sleep_o, .wdt_clear_o, .cycle_end_o,
    .store_stb_o, .store_addr_o, .store_data_o);

// ---- tb/mit_core_tb.sv ----
// Purpose: Self-checking bench for the instruction timing core
// Assumes: Program memory modelled here, answered on the falling edge
// Notes:   Rows run one program; sleep and a mid-run reset follow by hand
`timescale 1ns/1ns

module mit_core_tb;
    import mit_pkg::*;
    localparam int N = 46;
    logic            clk_sys_i;
    logic            resetn_i;
    logic [15:0]     prog_data_i;
    logic            wake_i;
    logic [PC_W-1:0] prog_addr_o, pc_o;
    logic [7:0]      acc_o, store_addr_o, store_data_o;
    logic            zero_o, carry_o, int_en_o, sleep_o, wdt_clear_o, cycle_end_o, store_stb_o;
    logic [15:0]     rom [2048];
    int              miscompares, checked, clocks, wdt_seen;
    logic [38:0]     r;
    // Row: address, word, instruction cycles, accumulator, zero and carry
    logic [38:0]     rows [N] = '{
        {11'h000,OP_MOV_AX,11'h0F0,2'h1,8'hF0,2'h0}, {11'h001,OP_ADD_AX,11'h020,2'h1,8'h10,2'h1},
        {11'h002,OP_MOV_MA,11'h010,2'h1,8'h10,2'h1}, {11'h003,OP_SUB_AX,11'h011,2'h1,8'hFF,2'h1},
        {11'h004,OP_AND_AX,11'h000,2'h1,8'h00,2'h3}, {11'h005,OP_INC_M,11'h010,2'h1,8'h00,2'h1},
        {11'h006,OP_DEC_A,11'h010,2'h1,8'h10,2'h1}, {11'h007,OP_ROT_LC,11'h110,2'h1,8'h23,2'h0},
        {11'h008,OP_BIT_HIGH,11'h710,2'h1,8'h23,2'h0}, {11'h009,OP_MOV_AM,11'h010,2'h1,8'h91,2'h0},
        {11'h00A,OP_SKIP_BZ,11'h010,2'h1,8'h91,2'h0}, {11'h00B,OP_SKIP_BNZ,11'h010,2'h2,8'h91,2'h0},
        {11'h00D,OP_CALL,11'h040,2'h2,8'h91,2'h0}, {11'h040,OP_XOR_AM,11'h010,2'h1,8'h00,2'h2},
        {11'h041,OP_MOV_MA,11'h002,2'h1,8'h00,2'h2}, {11'h042,OP_MISC,11'h100,2'h2,8'h00,2'h2},
        {11'h00E,OP_JUMP,11'h020,2'h2,8'h00,2'h2}, {11'h020,OP_MOV_AX,11'h02A,2'h1,8'h2A,2'h2},
        {11'h021,OP_MOV_MA,11'h000,2'h2,8'h2A,2'h2}, {11'h02A,OP_MOV_AX,11'h050,2'h1,8'h50,2'h2},
        {11'h02B,OP_MOV_MA,11'h001,2'h1,8'h50,2'h2}, {11'h02C,OP_MISC,11'h200,2'h2,8'h5A,2'h2},
        {11'h02D,OP_MOV_AM,11'h003,2'h1,8'hA5,2'h2}, {11'h02E,OP_MISC,11'h400,2'h1,8'hA5,2'h2},
        {11'h02F,OP_JUMP,11'h060,2'h2,8'hA5,2'h2}, {11'h060,OP_OR_AM,11'h010,2'h1,8'hB5,2'h0},
        {11'h061,OP_INV_A,11'h010,2'h1,8'h6E,2'h0}, {11'h062,OP_INV_M,11'h010,2'h1,8'h6E,2'h0},
        {11'h063,OP_ROT_L,11'h110,2'h1,8'hDC,2'h0}, {11'h064,OP_ADD_AM,11'h010,2'h1,8'h4A,2'h1},
        {11'h065,OP_ADC_AM,11'h010,2'h1,8'hB9,2'h0}, {11'h066,OP_MOV_AX,11'h000,2'h1,8'h00,2'h0},
        {11'h067,OP_SUB_AM,11'h010,2'h1,8'h92,2'h1}, {11'h068,OP_SBC_AM,11'h010,2'h1,8'h23,2'h0},
        {11'h069,OP_AND_AM,11'h010,2'h1,8'h22,2'h0}, {11'h06A,OP_INC_A,11'h010,2'h1,8'h6F,2'h0},
        {11'h06B,OP_DEC_M,11'h010,2'h1,8'h6F,2'h0}, {11'h06C,OP_ROT_R,11'h010,2'h1,8'h6F,2'h0},
        {11'h06D,OP_BIT_LOW,11'h710,2'h1,8'h6F,2'h0}, {11'h06E,OP_SKIP_Z,11'h010,2'h1,8'h6F,2'h0},
        {11'h06F,OP_MOV_AM,11'h010,2'h1,8'h36,2'h0}, {11'h070,OP_CALL,11'h080,2'h2,8'h36,2'h0},
        {11'h080,OP_SKIP_Z,11'h002,2'h2,8'h36,2'h0}, {11'h082,OP_MISC,11'h000,2'h2,8'h36,2'h0},
        {11'h071,OP_ROT_RC,11'h100,2'h1,8'h38,2'h1}, {11'h072,OP_MISC,11'h300,2'h1,8'h38,2'h1}};

    mit_core mit_core_inst (.clk_sys_i, .resetn_i, .prog_data_i, .wake_i, .prog_addr_o, .pc_o, .acc_o,
        .zero_o, .carry_o, .int_en_o, .sleep_o, .wdt_clear_o, .cycle_end_o, .store_stb_o, .store_addr_o,
        .store_data_o);

    // ==========================================================
    // Clock, program memory and watchdogs
    initial
    begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    always @(negedge clk_sys_i)
    begin
        prog_data_i <= rom[prog_addr_o];
        if (wdt_clear_o === 1'b1)
            wdt_seen++;
    end

    // Whole run needs well under 600 clocks
    always @(posedge clk_sys_i)
    begin
        clocks++;
        if (clocks == 2000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys_i iff cycle_end_o === 1'b1);
        // Registered copies settle one clock after the cycle-end pulse
        @(negedge clk_sys_i);
    endtask

    task automatic tally_and_finish();
        $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic hold_reset();
        resetn_i = 1'b0;
        repeat (20) @(negedge clk_sys_i);
        chk("reset acc", 16'h0000, 16'(acc_o));
        chk("reset pc", 16'h0000, 16'(pc_o));
        chk("reset int", 16'h0000, 16'(int_en_o));
        resetn_i = 1'b1;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        resetn_i = 1'b0;
        wake_i = 1'b0;
        prog_data_i = 16'h0000;
        foreach (rom[k]) rom[k] = 16'h0000;
        foreach (rows[k]) rom[rows[k][38:28]] = rows[k][27:12];
        rom[11'h00C] = {OP_MOV_AX, 11'h0FF};
        rom[11'h073] = {OP_MOV_AX, 11'h077};
        rom[11'h050] = 16'hA55A;
        hold_reset();
        $display("Reset test done");
        foreach (rows[i])
        begin
            r = rows[i];
            cycles(int'(r[11:10]));
            chk("acc", 16'(r[9:2]), 16'(acc_o));
            chk("flags", 16'(r[1:0]), 16'({zero_o, carry_o}));
            if (i < N - 1)
                chk("pc", 16'(rows[i + 1][38:28]), 16'(pc_o));
        end
        chk("int enable", 16'h0001, 16'(int_en_o));
        chk("store", 16'h1036, {store_addr_o, store_data_o});
        chk("fetch addr", 16'h0073, 16'(prog_addr_o));
        chk("wdt pulses", 16'h0001, 16'(wdt_seen));
        $display("Program rows done");
        repeat (12) @(negedge clk_sys_i);
        chk("asleep", 16'h0001, 16'(sleep_o));
        wake_i = 1'b1;
        cycles(3);
        wake_i = 1'b0;
        chk("awake", 16'h0000, 16'(sleep_o));
        chk("resume acc", 16'h0077, 16'(acc_o));
        $display("Sleep test done");
        hold_reset();
        cycles(1);
        chk("restart acc", 16'h00F0, 16'(acc_o));
        $display("Mid-run reset test done");
        tally_and_finish();
    end
endmodule
